// ===== core/link_regs_pkg.sv
// package: link register offsets, field layout, reset values and resource codes
package link_regs_pkg;
  // ==========================================================
  // register map
  localparam int unsigned REG_SPACE_BYTES = 2048;
  localparam logic [10:0] OFF_VERSION = 11'h000;
  localparam logic [10:0] OFF_RETRY = 11'h008;
  localparam logic [10:0] OFF_SWAP_NEW = 11'h00c;
  localparam logic [10:0] OFF_SWAP_EXP = 11'h010;
  localparam logic [10:0] OFF_SWAP_CTRL = 11'h014;
  localparam logic [10:0] OFF_HC_SET = 11'h050;
  localparam logic [10:0] OFF_HC_CLR = 11'h054;
  // ==========================================================
  // version codes per compatibility mode
  localparam logic [31:0] VERSION_MODE10 = 32'h0000_0010;
  localparam logic [31:0] VERSION_MODE11 = 32'h0000_0012;
  // ==========================================================
  // retry register fields
  localparam int unsigned RETRY_SEC_LSB = 29;
  localparam int unsigned RETRY_CYC_LSB = 16;
  localparam logic [2:0] SEC_MOD_MAX = 3'h7;
  localparam logic [12:0] CYC_MOD_MAX = 13'h1f3f;
  localparam logic [31:0] RETRY_WR_MASK = 32'h0000_0fff;
  // ==========================================================
  // swap control fields and resets
  localparam int unsigned CTRL_DONE_BIT = 31;
  localparam logic [31:0] CTRL_RESET = 32'h8000_0000;
  localparam logic [31:0] HC_WR_MASK = 32'h0006_0000;
  // ==========================================================
  // bus management resources
  typedef enum logic [1:0] {RES_BM_ID, RES_BW_AVAIL, RES_CH_HI, RES_CH_LO} res_sel_e;
  localparam logic [31:0] RST_BM_ID = 32'h0000_003f;
  localparam logic [31:0] RST_BW_AVAIL = 32'h0000_1333;
  localparam logic [31:0] RST_CH_AVAIL = 32'hffff_ffff;
  localparam logic [11:0] BUS_RES_BASE = 12'h21c;
  localparam logic [11:0] BUS_RES_LAST = 12'h228;
  localparam logic [11:0] BUS_ROM_LIMIT = 12'h400;
endpackage : link_regs_pkg

// ===== core/swap_if.sv
// interface: compare-and-swap request and reply between bank and engine
interface swap_if;
  logic req; // one-cycle request pulse
  logic [1:0] sel; // resource selected
  logic [31:0] expect_val; // value to compare
  logic [31:0] new_val; // value to store on match
  logic done; // one-cycle completion pulse
  logic [31:0] old_val; // value before the operation
  modport requester (output req, sel, expect_val, new_val, input done, old_val);
  modport engine (input req, sel, expect_val, new_val, output done, old_val);
endinterface : swap_if

// ===== core/swap_engine.sv
// file: the atomic bus management resource store with two swap ports
module swap_engine
  import link_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic bus_reset,
  swap_if.engine host,
  swap_if.engine bus,
  output logic [31:0] res_q [4]
);
  // ==========================================================
  // arbitration: one operation per cycle keeps each swap atomic
  wire bus_go = bus.req;
  wire host_go = host.req & ~bus.req;
  logic host_wait_q; // host request deferred by a bus request
  wire host_now = host_go | (host_wait_q & ~bus.req);
  wire [1:0] sel = bus_go ? bus.sel : host.sel;
  wire [31:0] cmp = bus_go ? bus.expect_val : host.expect_val;
  wire [31:0] nv = bus_go ? bus.new_val : host.new_val;
  logic [1:0] hsel_q;
  logic [31:0] hcmp_q;
  logic [31:0] hnew_q;
  wire [1:0] asel = (bus_go | host.req) ? sel : hsel_q;
  wire [31:0] acmp = (bus_go | host.req) ? cmp : hcmp_q;
  wire [31:0] anew = (bus_go | host.req) ? nv : hnew_q;
  wire act = bus_go | host_now;
  wire hit = res_q[asel] == acmp; // full 32-bit test
  // ==========================================================
  // resources: reset values on hardware or bus reset
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || bus_reset)
    begin
      res_q[0] <= RST_BM_ID;
      res_q[1] <= RST_BW_AVAIL;
      res_q[2] <= RST_CH_AVAIL;
      res_q[3] <= RST_CH_AVAIL;
    end
    else if (act && hit)
    begin
      res_q[asel] <= anew;
    end
  end
  // ==========================================================
  // replies and deferred host request
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      host_wait_q <= 1'b0;
      hsel_q <= 2'h0;
      hcmp_q <= 32'h0;
      hnew_q <= 32'h0;
      host.done <= 1'b0;
      host.old_val <= 32'h0;
      bus.done <= 1'b0;
      bus.old_val <= 32'h0;
    end
    else
    begin
      if (host.req)
      begin
        hsel_q <= host.sel;
        hcmp_q <= host.expect_val;
        hnew_q <= host.new_val;
      end
      host_wait_q <= (host.req | host_wait_q) & bus.req;
      host.done <= host_now;
      bus.done <= bus_go;
      if (host_now)
        host.old_val <= res_q[asel];
      if (bus_go)
        bus.old_val <= res_q[asel];
    end
  end
  // a bus swap that matches stores its new value in the selected resource
  AST_SWAP_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n || bus_reset)
    bus_go && hit |=> res_q[$past(asel)] == $past(anew))
    else $error("matching swap did not store new value");
endmodule // swap_engine

// ===== core/ohci_link_regs_compare_swap.sv
// file: link register bank with retry limits and compare-and-swap front end
// ==========================================================
// Summary of operation
// - decode 2048-byte register block
// - block starts at programmed base address
// - fields reset zero except done, survive bus reset
// - set address sets, clear address clears
// - both pair addresses read shared register
// - version code follows compatibility mode
// - seconds field counts modulo 8
// - cycle field counts modulo 8000
// - physical response retry limit field
// - response retry limit field
// - request retry limit field
// - bus lock requests served autonomously
// - control write starts one swap
// - completion sets done, returns old value
// - store only on equal compare
// - compare uses full 32 bits
// - bus side: quadlet read and lock
// - resources at consecutive bus addresses
// - resources reload on resets
// - bus may read first 1K of ROM
// - control resets to top bit set
// - done clears on write, sets on completion
// - select codes choose the four resources
module ohci_link_regs_compare_swap
  import link_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic bus_reset, // one-cycle 1394 bus reset from the link
  input wire logic mode_11, // compatibility mode, high selects 1.1
  input wire logic [31:0] bar_base, // programmed memory base address
  input wire logic mem_req, // memory access strobe
  input wire logic mem_we, // high for write
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_hit, // access falls in this block
  output logic [31:0] mem_rdata,
  output logic mem_rvalid,
  input wire logic cycle_tick, // one pulse per 1394 cycle
  input wire logic retry_start, // restart the retry time count
  input wire logic lk_req, // 1394 side request
  input wire logic lk_lock, // high for lock, low for read
  input wire logic [11:0] lk_offset, // low bits of 1394 offset
  input wire logic lk_quad, // request is exactly one quadlet
  input wire logic [31:0] lk_arg, // lock compare value
  input wire logic [31:0] lk_data, // lock new value
  output logic lk_ack, // one-cycle answer
  output logic lk_err, // answered with type error
  output logic lk_rom, // read goes to the config ROM image
  output logic [31:0] lk_rdata,
  output logic [3:0] phys_resp_retries,
  output logic [3:0] resp_retries,
  output logic [3:0] req_retries,
  output logic [1:0] hc_ctrl
);
  import link_regs_pkg::*;
  // ==========================================================
  // address decode
  wire [31:0] base_mask = ~32'(REG_SPACE_BYTES - 1);
  wire in_block = (mem_addr & base_mask) == (bar_base & base_mask);
  wire [10:0] off = mem_addr[10:0];
  wire wr = mem_req & mem_we & in_block; // aligned words assumed
  wire rd = mem_req & ~mem_we & in_block;
  wire wr_retry = wr && off == OFF_RETRY;
  wire wr_new = wr && off == OFF_SWAP_NEW;
  wire wr_exp = wr && off == OFF_SWAP_EXP;
  wire wr_ctrl = wr && off == OFF_SWAP_CTRL;
  wire wr_set = wr && off == OFF_HC_SET;
  wire wr_clr = wr && off == OFF_HC_CLR;
  assign mem_hit = mem_req & in_block;
  // ==========================================================
  // storage
  logic [11:0] retry_q; // writable retry limits
  logic [2:0] sec_q; // seconds of retry time
  logic [12:0] cyc_q; // cycles of retry time
  logic [31:0] new_q;
  logic [31:0] exp_q;
  logic done_q;
  logic [1:0] sel_q;
  logic [31:0] hc_q;
  logic [31:0] res_q [4];
  swap_if host_sw ();
  swap_if bus_sw ();
  // ==========================================================
  // retry limit fields steer the transmit side
  assign phys_resp_retries = retry_q[11:8];
  assign resp_retries = retry_q[7:4];
  assign req_retries = retry_q[3:0];
  assign hc_ctrl = hc_q[18:17];
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      retry_q <= 12'h0;
    else if (wr_retry)
      retry_q <= mem_wdata[11:0] & RETRY_WR_MASK[11:0];
  end
  // ==========================================================
  // retry time count: cycles modulo 8000 carry into seconds modulo 8
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || retry_start)
    begin
      sec_q <= 3'h0;
      cyc_q <= 13'h0;
    end
    else if (cycle_tick)
    begin
      if (cyc_q == CYC_MOD_MAX)
      begin
        cyc_q <= 13'h0;
        sec_q <= (sec_q == SEC_MOD_MAX) ? 3'h0 : sec_q + 3'h1;
      end
      else
        cyc_q <= cyc_q + 13'h1;
    end
  end
  // ==========================================================
  // set/clear pair for link control bits
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      hc_q <= 32'h0;
    else if (wr_set)
      hc_q <= hc_q | (mem_wdata & HC_WR_MASK);
    else if (wr_clr)
      hc_q <= hc_q & ~(mem_wdata & HC_WR_MASK);
  end
  // ==========================================================
  // host swap registers; a write to control starts one swap
  assign host_sw.req = wr_ctrl;
  assign host_sw.sel = mem_wdata[1:0];
  assign host_sw.expect_val = exp_q;
  assign host_sw.new_val = new_q;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      new_q <= 32'h0;
      exp_q <= 32'h0;
      done_q <= CTRL_RESET[CTRL_DONE_BIT];
      sel_q <= 2'h0;
    end
    else
    begin
      if (host_sw.done)
        new_q <= host_sw.old_val;
      else if (wr_new)
        new_q <= mem_wdata;
      if (wr_exp)
        exp_q <= mem_wdata;
      // completion wins over a write in the same cycle
      if (host_sw.done)
        done_q <= 1'b1;
      else if (wr_ctrl)
        done_q <= 1'b0;
      if (wr_ctrl)
        sel_q <= mem_wdata[1:0];
    end
  end
  // ==========================================================
  // read mux
  logic [31:0] rmux;
  always_comb
  begin
    unique case (off)
      OFF_VERSION: rmux = mode_11 ? VERSION_MODE11 : VERSION_MODE10;
      OFF_RETRY: rmux = {sec_q, cyc_q, 4'h0, retry_q};
      OFF_SWAP_NEW: rmux = new_q;
      OFF_SWAP_EXP: rmux = exp_q;
      OFF_SWAP_CTRL: rmux = {done_q, 29'h0, sel_q};
      OFF_HC_SET, OFF_HC_CLR: rmux = hc_q;
      default: rmux = 32'h0; // reserved reads zero
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mem_rdata <= 32'h0;
      mem_rvalid <= 1'b0;
    end
    else
    begin
      mem_rvalid <= rd;
      if (rd)
        mem_rdata <= rmux;
    end
  end
  // ==========================================================
  // 1394 side: resource decode, quadlet read and lock only
  wire lk_res = lk_offset >= BUS_RES_BASE && lk_offset <= BUS_RES_LAST && lk_offset[1:0] == 2'h0;
  wire [1:0] lk_sel = 2'(((lk_offset - BUS_RES_BASE) >> 2));
  wire lk_romreq = lk_offset < BUS_ROM_LIMIT && !lk_lock && lk_quad;
  wire lk_ok = lk_quad && lk_res;
  assign bus_sw.req = lk_req & lk_ok & lk_lock;
  assign bus_sw.sel = lk_sel;
  assign bus_sw.expect_val = lk_arg;
  assign bus_sw.new_val = lk_data;
  logic lk_rd_q; // plain read answered next cycle
  logic lk_err_q;
  logic [31:0] lk_rd_val_q;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      lk_rd_q <= 1'b0;
      lk_err_q <= 1'b0;
      lk_rom <= 1'b0;
      lk_rd_val_q <= 32'h0;
    end
    else
    begin
      lk_rd_q <= lk_req & lk_ok & ~lk_lock;
      lk_err_q <= lk_req & ~lk_ok & ~lk_romreq;
      lk_rom <= lk_req & ~lk_ok & lk_romreq;
      if (lk_req)
        lk_rd_val_q <= res_q[lk_sel];
    end
  end
  assign lk_ack = bus_sw.done | lk_rd_q | lk_err_q | lk_rom;
  assign lk_err = lk_err_q;
  assign lk_rdata = bus_sw.done ? bus_sw.old_val : (lk_rd_q ? lk_rd_val_q : 32'h0);
  // ==========================================================
  // atomic store
  swap_engine u_engine (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .bus_reset(bus_reset),
    .host(host_sw.engine),
    .bus(bus_sw.engine),
    .res_q(res_q)
  );
  // ==========================================================
  // checks
  AST_CTRL_RESET: assert property (@(posedge ref_clk)
    !reset_n |=> done_q && sel_q == 2'h0)
    else $error("control not at reset value");
  AST_DONE_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_ctrl && !host_sw.done |=> !done_q)
    else $error("done not cleared by control write");
  AST_DONE_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_ctrl |-> ##[1:3] done_q)
    else $error("host swap did not complete");
  AST_OLD_VALUE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    host_sw.done |=> new_q == $past(host_sw.old_val))
    else $error("data register not loaded with old value");
  AST_SET_BITS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_set |=> (hc_q & ($past(mem_wdata) & HC_WR_MASK)) == ($past(mem_wdata) & HC_WR_MASK))
    else $error("set write left bit clear");
  AST_CLR_BITS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_clr |=> (hc_q & $past(mem_wdata)) == 32'h0)
    else $error("clear write left bit set");
  AST_CYC_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cyc_q <= CYC_MOD_MAX)
    else $error("cycle count beyond modulo");
  AST_VERSION: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd && off == OFF_VERSION |=> mem_rdata == ($past(mode_11) ? VERSION_MODE11 : VERSION_MODE10))
    else $error("wrong version code");
  AST_BUS_RESET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bus_reset |=> res_q[0] == RST_BM_ID && res_q[3] == RST_CH_AVAIL)
    else $error("resources not reloaded on bus reset");
endmodule // ohci_link_regs_compare_swap

// ===== sim/host_model.sv
// host model: single-word memory accesses and the swap sequence
module host_model
(
  input wire logic ref_clk,
  input wire logic mem_hit,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // idle bus at time zero
  initial
  begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = 32'h0;
    mem_wdata = 32'h0;
  end
  // ==========================================================
  // one aligned word per request, held over the taking edge only
  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d, output logic hit,
    output logic [31:0] q);
    @(posedge ref_clk);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= {a[31:2], 2'b00};
    mem_wdata <= d;
    #1 hit = mem_hit;
    @(posedge ref_clk);
    mem_req <= 1'b0;
    // released lines are inverted so stale values never look valid
    mem_addr <= ~a;
    mem_wdata <= ~d;
    q = 'x;
    #1;
    for (int k = 0; k < 4 && !we; k++)
    begin
      if (mem_rvalid === 1'b1)
      begin
        q = mem_rdata;
        break;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask
  // ==========================================================
  // host swap: new value, expected value, then select
  task automatic swap(input logic [31:0] base, input logic [1:0] sel, input logic [31:0] nv,
    input logic [31:0] ev);
    logic h;
    logic [31:0] q;
    access(1'b1, base + 32'h0c, nv, h, q);
    access(1'b1, base + 32'h10, ev, h, q);
    access(1'b1, base + 32'h14, {30'h0, sel}, h, q);
  endtask
endmodule // host_model

// ===== sim/ohci_link_regs_compare_swap_tb.sv
// testbench: register bank, host swap and link locks against a model
module ohci_link_regs_compare_swap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import link_regs_pkg::*;
  // ==========================================================
  // signals and model state
  logic ref_clk, reset_n, bus_reset, mode_11, cycle_tick, retry_start;
  logic lk_req, lk_lock, lk_quad, lk_ack, lk_err, lk_rom;
  logic mem_req, mem_we, mem_hit, mem_rvalid;
  logic [31:0] bar_base, mem_addr, mem_wdata, mem_rdata, lk_arg, lk_data, lk_rdata;
  logic [11:0] lk_offset;
  logic [3:0] phys_resp_retries, resp_retries, req_retries;
  logic [1:0] hc_ctrl;
  logic [31:0] res_m [4]; // resource model
  logic [31:0] v, e, nv, ev;
  logic [31:0] rl; // expected writable retry limits, kept past later reuse of e
  logic [34:0] r; // ack, err, rom, data of last link answer
  int error_cnt, n_checks, cyc;
  integer seed = 32'habd7e8b2;
  ohci_link_regs_compare_swap dut_u (.ref_clk, .reset_n, .bus_reset, .mode_11, .bar_base, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_hit, .mem_rdata, .mem_rvalid, .cycle_tick, .retry_start, .lk_req, .lk_lock,
    .lk_offset, .lk_quad, .lk_arg, .lk_data, .lk_ack, .lk_err, .lk_rom, .lk_rdata, .phys_resp_retries,
    .resp_retries, .req_retries, .hc_ctrl);
  host_model host_u (.ref_clk, .mem_hit, .mem_rvalid, .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata);
  // ==========================================================
  // clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================
  // compare, access helpers and verdict
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] off, input logic [31:0] exp, input logic eh);
    logic h;
    logic [31:0] q;
    host_u.access(1'b0, bar_base + off, 32'h0, h, q);
    chk32({31'h0, h}, {31'h0, eh});
    if (eh)
      chk32(q, exp);
  endtask
  task automatic wr(input logic [31:0] off, input logic [31:0] d);
    logic h;
    logic [31:0] q;
    host_u.access(1'b1, bar_base + off, d, h, q);
  endtask
  // link request held over one taking edge; answer sampled just after it
  task automatic link_op(input logic lock, input logic [11:0] off, input logic quad, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    lk_req <= 1'b1;
    lk_lock <= lock;
    lk_offset <= off;
    lk_quad <= quad;
    lk_arg <= a;
    lk_data <= d;
    @(posedge ref_clk);
    lk_req <= 1'b0;
    lk_arg <= ~a;
    lk_data <= ~d;
    #1 r = {lk_ack, lk_err, lk_rom, lk_rdata};
  endtask
  task automatic res_read(input int s);
    link_op(1'b0, BUS_RES_BASE + 12'(s * 4), 1'b1, 32'h0, 32'h0);
    chk32({29'h0, r[34:32]}, 32'h4);
    chk32(r[31:0], res_m[s]);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    {reset_n, bus_reset, mode_11, cycle_tick, retry_start, lk_req, lk_lock, lk_quad} = 8'h0;
    {lk_offset, lk_arg, lk_data} = '0;
    bar_base = {$random(seed), 11'h0} >> 11 << 11;
    res_m = '{RST_BM_ID, RST_BW_AVAIL, RST_CH_AVAIL, RST_CH_AVAIL};
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFF_VERSION, VERSION_MODE10, 1'b1);
    @(posedge ref_clk);
    mode_11 <= 1'b1;
    rd(OFF_VERSION, VERSION_MODE11, 1'b1);
    rd(OFF_RETRY, 32'h0, 1'b1);
    rd(OFF_SWAP_NEW, 32'h0, 1'b1);
    rd(OFF_SWAP_EXP, 32'h0, 1'b1);
    rd(OFF_SWAP_CTRL, CTRL_RESET, 1'b1);
    rd(32'h7fc, 32'h0, 1'b1);
    rd(32'h800, 32'h0, 1'b0);
    for (int s = 0; s < 4; s++)
      res_read(s);
    // retry limits: writable low fields only, mirrored on the ports
    v = $random(seed);
    wr(OFF_RETRY, v);
    e = v & RETRY_WR_MASK;
    rl = e;
    rd(OFF_RETRY, e, 1'b1);
    chk32({20'h0, phys_resp_retries, resp_retries, req_retries}, e);
    // time count: one full cycle wrap plus one
    @(posedge ref_clk);
    retry_start <= 1'b1;
    @(posedge ref_clk);
    retry_start <= 1'b0;
    cycle_tick <= 1'b1;
    repeat (8001) @(posedge ref_clk);
    cycle_tick <= 1'b0;
    rd(OFF_RETRY, {3'h1, 13'h1, 4'h0, e[11:0]}, 1'b1);
    // set/clear pair
    v = $random(seed) | 32'h0006_0000;
    wr(OFF_HC_SET, v);
    e = v & HC_WR_MASK;
    rd(OFF_HC_SET, e, 1'b1);
    rd(OFF_HC_CLR, e, 1'b1);
    chk32({30'h0, hc_ctrl}, {30'h0, e[18:17]});
    wr(OFF_HC_CLR, 32'hfffd_ffff);
    rd(OFF_HC_CLR, 32'h0002_0000, 1'b1);
    // host swaps: even selects miss by one bit, odd ones match
    for (int s = 0; s < 4; s++)
    begin
      nv = $random(seed);
      ev = s[0] ? res_m[s] : res_m[s] ^ (32'h1 << (s * 15 + 1));
      host_u.swap(bar_base, s[1:0], nv, ev);
      rd(OFF_SWAP_CTRL, CTRL_RESET | s, 1'b1);
      rd(OFF_SWAP_NEW, res_m[s], 1'b1);
      if (ev == res_m[s])
        res_m[s] = nv;
      res_read(s);
    end
    // bus locks: odd selects miss on the top bit
    for (int s = 0; s < 4; s++)
    begin
      nv = $random(seed);
      ev = s[0] ? res_m[s] ^ 32'h8000_0000 : res_m[s];
      link_op(1'b1, BUS_RES_BASE + 12'(s * 4), 1'b1, ev, nv);
      chk32({29'h0, r[34:32]}, 32'h4);
      chk32(r[31:0], res_m[s]);
      if (ev == res_m[s])
        res_m[s] = nv;
      res_read(s);
    end
    link_op(1'b1, BUS_RES_BASE, 1'b0, 32'h0, 32'h0);
    chk32({29'h0, r[34:32]}, 32'h6);
    link_op(1'b0, 12'h100, 1'b1, 32'h0, 32'h0);
    chk32({29'h0, r[34:32]}, 32'h5);
    link_op(1'b0, 12'h500, 1'b1, 32'h0, 32'h0);
    chk32({29'h0, r[34:32]}, 32'h6);
    // bus reset reloads resources and leaves registers alone
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    res_m = '{RST_BM_ID, RST_BW_AVAIL, RST_CH_AVAIL, RST_CH_AVAIL};
    for (int s = 0; s < 4; s++)
      res_read(s);
    rd(OFF_RETRY, {3'h1, 13'h1, 4'h0, rl[11:0]}, 1'b1);
    rd(OFF_HC_SET, 32'h0002_0000, 1'b1);
    report_and_stop();
  end
endmodule // ohci_link_regs_compare_swap_tb
